//--- pkg/tmc_consts.svh
// constants for the timer control block: register offsets, fields, reset values, divider counts
// assumes a classic wishbone slave with 32-bit data and word-aligned offsets
//
// Function
// RULE1 - low-byte irq enable plus timer irq enable: interrupt on each low-byte overflow
// RULE2 - capture enabled: copy 16-bit count into reload bytes on comparator rising edge
// RULE3 - with timer irq enabled, every capture event also requests an interrupt
// RULE4 - split select 0 gives one 16-bit reload timer, 1 gives two 8-bit ones
// RULE5 - run bit enables counting; in split mode only high byte gated, low always counts
// RULE6 - control bit 1 reads zero and writes to it are ignored
// RULE7 - external select 0: system clock/12; 1: synchronized external clock/8
// RULE8 - in split mode external select serves both bytes; per-byte system_clock select overrides
// RULE9 - high flag sets on high byte FF to 00; low flag on low byte FF to 00
// RULE10 - hardware never clears overflow flags; software clears them by writing
// RULE11 - each overflow reloads the overflowing counter or byte from its reload register
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
// ==========================================
// register offsets (byte addresses)
`define TMC_OFS_CTRL 4'h0
`define TMC_OFS_CLKCTL 4'h4
`define TMC_OFS_COUNT 4'h8
`define TMC_OFS_RELOAD 4'hC
// ==========================================
// control register fields
`define TMC_B_XCLK 0
`define TMC_B_UNUSED 1
`define TMC_B_RUN 2
`define TMC_B_SPLIT 3
`define TMC_B_CAPEN 4
`define TMC_B_LIEN 5
`define TMC_B_LFLAG 6
`define TMC_B_HFLAG 7
`define TMC_CTRL_WMASK 8'hFD
`define TMC_CTRL_RST 8'h00
// clock-control fields: bit 0 low byte system_clock select, bit 1 high byte
`define TMC_B_LSYS 0
`define TMC_B_HSYS 1
`define TMC_CLKCTL_RST 2'h0
`define TMC_COUNT_RST 16'h0000
`define TMC_RELOAD_RST 16'h0000
// ==========================================
// prescaler counts
`define TMC_DIV_SYS 12
`define TMC_DIV_EXT 8
`define TMC_BYTE_MAX 8'hFF
`endif

//--- pkg/tmc_pkg.sv
// types for the timer control block
// assumes tmc_consts.svh is included by the design files
package tmc_pkg;
   // ==========================================
   // control register image
   typedef struct packed {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_byte_irq_enable;
      logic comparator_capture_enable;
      logic split_mode_select;
      logic run_control;
      logic unused;
      logic external_clock_select;
   } tmc_ctrl_t;
   // per-byte tick enables
   typedef struct packed {
      logic high;
      logic low;
   } tmc_tick_t;
endpackage

//--- hw/tmc_tick_gen.sv
// tick generator: system clock /12 and synchronized external clock /8
// assumes ext_clk_i is synchronous to clk_i already (sampled as a level)
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tmc_tick_gen (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ext_clk_i,
   input wire logic ext_sel_i,
   input wire logic [1:0] sys_sel_i,
   output tmc_pkg::tmc_tick_t tick_o
);
   logic [3:0] sys_cnt_q;
   logic [2:0] ext_cnt_q;
   logic ext_prev_q;
   logic sys_tick;
   logic ext_tick;
   logic rise;
   // ==========================================
   // prescalers
   assign sys_tick = (sys_cnt_q == 4'(`TMC_DIV_SYS - 1));
   assign rise = ext_clk_i & ~ext_prev_q;
   assign ext_tick = rise && (ext_cnt_q == 3'(`TMC_DIV_EXT - 1));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_cnt_q <= 4'h0;
      end else if (sys_tick) begin
         sys_cnt_q <= 4'h0;
      end else begin
         sys_cnt_q <= sys_cnt_q + 4'h1;
      end
   end
   // external edges counted in the system domain, so max external rate is half of clk
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_prev_q <= 1'b0;
         ext_cnt_q <= 3'h0;
      end else begin
         ext_prev_q <= ext_clk_i;
         if (rise) begin
            ext_cnt_q <= ext_cnt_q + 3'h1;
         end
      end
   end
   // per-byte select: system_clock select overrides, else external or system_clock/12
   always_comb begin
      tick_o.low = sys_sel_i[`TMC_B_LSYS] ? 1'b1 : (ext_sel_i ? ext_tick : sys_tick); // see RULE7 see RULE8
      tick_o.high = sys_sel_i[`TMC_B_HSYS] ? 1'b1 : (ext_sel_i ? ext_tick : sys_tick); // see RULE8
   end
endmodule // tmc_tick_gen

//--- hw/tmc_timer.sv
// timer with control register, split/16-bit auto-reload and comparator capture
// assumes a classic wishbone master, cmp_i and ext_clk_i synchronous to clk_i
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tmc_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_clk_i,
   input wire logic comparator_output_i,
   input wire logic timer_irq_enable_i,
   output logic timer_irq_o
);
   tmc_pkg::tmc_ctrl_t ctrl_q;
   logic [1:0] clkctl_q;
   logic [7:0] count_low_byte_q;
   logic [7:0] count_high_byte_q;
   logic [7:0] reload_low_byte_q;
   logic [7:0] reload_high_byte_q;
   logic cmp_prev_q;
   tmc_pkg::tmc_tick_t tick;
   logic req;
   logic wr;
   logic lo_en;
   logic hi_en;
   logic lo_ovf;
   logic hi_ovf;
   logic capture;
   logic [31:0] rdata;

   tmc_tick_gen u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ext_clk_i(ext_clk_i),
      .ext_sel_i(ctrl_q.external_clock_select),
      .sys_sel_i(clkctl_q),
      .tick_o(tick)
   );

   // ==========================================
   // bus decode
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i & wb_sel_i[0];

   // ==========================================
   // counting
   // 16-bit mode: high byte advances only on low-byte wrap, on the low byte's tick
   always_comb begin
      if (ctrl_q.split_mode_select) begin // see RULE4
         lo_en = tick.low; // see RULE5
         hi_en = tick.high & ctrl_q.run_control; // see RULE5
      end else begin
         lo_en = tick.low & ctrl_q.run_control; // see RULE5
         hi_en = lo_en & (count_low_byte_q == `TMC_BYTE_MAX);
      end
   end
   assign lo_ovf = lo_en & (count_low_byte_q == `TMC_BYTE_MAX); // see RULE9
   assign hi_ovf = hi_en & (count_high_byte_q == `TMC_BYTE_MAX); // see RULE9
   assign capture = ctrl_q.comparator_capture_enable & comparator_output_i & ~cmp_prev_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_low_byte_q <= 8'(`TMC_COUNT_RST);
         count_high_byte_q <= 8'(`TMC_COUNT_RST >> 8);
      end else if (wr && hit(wb_adr_i, `TMC_OFS_COUNT)) begin
         count_low_byte_q <= wb_dat_i[7:0];
         count_high_byte_q <= wb_sel_i[1] ? wb_dat_i[15:8] : count_high_byte_q;
      end else begin
         // 16-bit mode reloads both bytes only on a full wrap
         if (ctrl_q.split_mode_select) begin
            if (lo_ovf) count_low_byte_q <= reload_low_byte_q; // see RULE11
            else if (lo_en) count_low_byte_q <= count_low_byte_q + 8'h01;
            if (hi_ovf) count_high_byte_q <= reload_high_byte_q; // see RULE11
            else if (hi_en) count_high_byte_q <= count_high_byte_q + 8'h01;
         end else if (hi_ovf) begin
            count_low_byte_q <= reload_low_byte_q; // see RULE11
            count_high_byte_q <= reload_high_byte_q; // see RULE11
         end else if (lo_en) begin
            count_low_byte_q <= count_low_byte_q + 8'h01;
            if (hi_en) count_high_byte_q <= count_high_byte_q + 8'h01;
         end
      end
   end

   // ==========================================
   // reload registers and capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload_low_byte_q <= 8'h00;
         reload_high_byte_q <= 8'h00;
         cmp_prev_q <= 1'b0;
      end else begin
         cmp_prev_q <= comparator_output_i;
         if (capture) begin
            reload_low_byte_q <= count_low_byte_q; // see RULE2
            reload_high_byte_q <= count_high_byte_q; // see RULE2
         end else if (wr && hit(wb_adr_i, `TMC_OFS_RELOAD)) begin
            reload_low_byte_q <= wb_dat_i[7:0];
            if (wb_sel_i[1]) reload_high_byte_q <= wb_dat_i[15:8];
         end
      end
   end

   // ==========================================
   // control and clock-control registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `TMC_CTRL_RST;
         clkctl_q <= `TMC_CLKCTL_RST;
      end else begin
         if (wr && hit(wb_adr_i, `TMC_OFS_CTRL)) begin
            ctrl_q <= wb_dat_i[7:0] & `TMC_CTRL_WMASK; // see RULE6
         end
         // hardware only sets; a set in the cycle of a software clear wins
         if (hi_ovf) ctrl_q.high_overflow_flag <= 1'b1; // see RULE9 see RULE10
         if (lo_ovf) ctrl_q.low_overflow_flag <= 1'b1; // see RULE9 see RULE10
         if (wr && hit(wb_adr_i, `TMC_OFS_CLKCTL)) begin
            clkctl_q <= wb_dat_i[1:0];
         end
      end
   end

   // ==========================================
   // interrupt request: one-cycle pulse per cycle with an enabled event, registered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_irq_o <= 1'b0;
      end else begin
         timer_irq_o <= timer_irq_enable_i &
            (hi_ovf | (lo_ovf & ctrl_q.low_byte_irq_enable) | capture); // see RULE1 see RULE3
      end
   end

   // ==========================================
   // read mux and ack; unmapped offsets read zero and still ack
   always_comb begin
      rdata = 32'h0000_0000;
      if (hit(wb_adr_i, `TMC_OFS_CTRL)) rdata[7:0] = ctrl_q & `TMC_CTRL_WMASK; // see RULE6
      if (hit(wb_adr_i, `TMC_OFS_CLKCTL)) rdata[1:0] = clkctl_q;
      if (hit(wb_adr_i, `TMC_OFS_COUNT)) rdata[15:0] = {count_high_byte_q, count_low_byte_q};
      if (hit(wb_adr_i, `TMC_OFS_RELOAD)) rdata[15:0] = {reload_high_byte_q, reload_low_byte_q};
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rdata : 32'h0000_0000;
      end
   end
endmodule // tmc_timer

//--- tb/tmc_timer_checker.sv
// checker for tmc_timer: bus handshake, read data and interrupt gating
// assumes it is bound to tmc_timer and sees only its ports
`timescale 1ns/1ps
module tmc_timer_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic ext_clk_i,
   input wire logic comparator_output_i,
   input wire logic timer_irq_enable_i,
   input wire logic timer_irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================
   // bus
   property p_ack_in; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_in: assert property (p_ack_in) else $error("request not answered");
   property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_ctrl_hi; wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
   a_ctrl_hi: assert property (p_ctrl_hi) else $error("control upper bits not zero");
   property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0000_0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   // ==========================================
   // control bit 1 and interrupt
   property p_bit1; wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> !wb_dat_o[1]; endproperty
   a_bit1: assert property (p_bit1) else $error("control bit 1 reads one");
   property p_irq_en; timer_irq_o |-> $past(timer_irq_enable_i); endproperty
   a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");
   c_irq: cover property (timer_irq_o);
   c_cmp: cover property (timer_irq_enable_i && $rose(comparator_output_i));
   c_wr: cover property (wb_ack_o && wb_we_i);
endmodule // tmc_timer_checker
bind tmc_timer tmc_timer_checker u_chk (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .ext_clk_i(ext_clk_i),
   .comparator_output_i(comparator_output_i),
   .timer_irq_enable_i(timer_irq_enable_i),
   .timer_irq_o(timer_irq_o)
);

//--- tb/tb_timer2_control_bits.sv
// testbench for tmc_timer: register traffic, counting, capture, interrupts
// assumes design and checker are compiled first
`timescale 1ns/1ps
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("BAD %0t mismatch got %h want %h", $time, a, b); end end
module tb_timer2_control_bits;
   localparam logic [31:0] M = 32'hFFFF_FFFF;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ext = 0, cmp = 0, ien = 0;
   logic [3:0] adr = 4'h0, sel = 4'hF;
   logic [31:0] wdat = 32'h0000_0000, rdat, r;
   logic ack, irq;
   logic [31:0] eq[$], mq[$];
   int fails = 0, total_checks = 0, irqs = 0;
   tmc_timer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_clk_i(ext),
      .comparator_output_i(cmp), .timer_irq_enable_i(ien), .timer_irq_o(irq));
   initial forever #50 clk_i = ~clk_i;
   // ==========================================
   // one classic cycle; reads leave their expectation for the monitor
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      if (!w) begin
         eq.push_back(d);
         mq.push_back(m);
      end
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 0;
      stb <= 0;
   endtask
   always @(posedge clk_i) begin
      if (irq === 1'b1) irqs++;
      if (ack === 1'b1 && we === 1'b0) begin
         `CHK(rdat & mq[0], eq[0] & mq[0])
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
   end
   task automatic stop_test;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles used
   initial begin
      #2_000_000;
      fails++;
      stop_test();
   end
   // ==========================================
   initial begin
      void'($urandom(32'hd5306ef5));
      repeat (5) @(posedge clk_i);
      rst_i <= 0;
      bus(0, 4'h0, 32'h0000_0000, M);
      bus(0, 4'h8, 32'h0000_0000, M);
      bus(0, 4'hC, 32'h0000_0000, M);
      bus(0, 4'h2, 32'h0000_0000, M);
      // run and flags kept clear so nothing counts far
      repeat (4) begin
         r = $urandom & 32'h0000_003B | 32'h0000_0002;
         bus(1, 4'h0, r, M);
         bus(0, 4'h0, r & 32'h0000_00FD, M);
      end
      r = $urandom & 32'h0000_FFFF;
      bus(1, 4'h0, 32'h0000_0010, M);
      bus(1, 4'h8, r, M);
      ien <= 1;
      @(posedge clk_i) cmp <= 1;
      repeat (3) @(posedge clk_i);
      cmp <= 0;
      bus(0, 4'hC, r, M);
      `CHK(irqs, 1)
      bus(1, 4'h4, 32'h0000_0003, M);
      bus(1, 4'hC, 32'h0000_FF00, M);
      bus(1, 4'h8, 32'h0000_FFFC, M);
      bus(1, 4'h0, 32'h0000_0004, M);
      repeat (20) @(posedge clk_i);
      bus(0, 4'h0, 32'h0000_00C4, M);
      bus(0, 4'h8, 32'h0000_FF00, 32'h0000_FF00);
      `CHK(irqs, 2)
      repeat (20) @(posedge clk_i);
      bus(0, 4'h0, 32'h0000_00C4, M);
      bus(1, 4'h0, 32'h0000_0000, M);
      bus(0, 4'h0, 32'h0000_0000, M);
      bus(1, 4'h4, 32'h0000_0001, M);
      bus(1, 4'h8, 32'h0000_00F0, M);
      bus(1, 4'h0, 32'h0000_0028, M);
      repeat (40) @(posedge clk_i);
      bus(0, 4'h0, 32'h0000_0068, M);
      bus(0, 4'h8, 32'h0000_0000, 32'h0000_FF00);
      `CHK(irqs, 3)
      bus(1, 4'h0, 32'h0000_0000, M);
      bus(1, 4'h4, 32'h0000_0000, M);
      bus(1, 4'h8, 32'h0000_0000, M);
      bus(1, 4'h0, 32'h0000_0005, M);
      // external clock kept well under half the system clock
      repeat (32) begin
         repeat (2) @(posedge clk_i);
         ext <= ~ext;
      end
      repeat (4) @(posedge clk_i);
      bus(1, 4'h0, 32'h0000_0000, M);
      bus(0, 4'h8, 32'h0000_0002, M);
      // system_clock/12: run window is 36 edges, so exactly 3 ticks whatever the prescaler phase
      bus(1, 4'h8, 32'h0000_0000, M);
      bus(1, 4'h0, 32'h0000_0004, M);
      repeat (33) @(posedge clk_i);
      bus(1, 4'h0, 32'h0000_0000, M);
      bus(0, 4'h8, 32'h0000_0003, M);
      // byte lanes: lane 1 gates the high byte, no lane 0 means no write
      sel <= 4'h1;
      bus(1, 4'h8, 32'h0000_1234, M);
      sel <= 4'h2;
      bus(1, 4'h0, 32'h0000_00FF, M);
      sel <= 4'hF;
      bus(0, 4'h8, 32'h0000_0034, M);
      bus(0, 4'h0, 32'h0000_0000, M);
      stop_test();
   end
endmodule // tb_timer2_control_bits
